// ---- hw/jcp_map.vh ----
// Purpose: Constants for the test-port configuration block
// Assumes: Included by bare name from hw design files
// Notes: Instruction codes are a plain chosen set, 4 bits wide
`ifndef JCP_MAP_VH
`define JCP_MAP_VH

`define JCP_IR_WIDTH 4
`define JCP_IR_BYPASS 4'h_F
`define JCP_IR_IDCODE 4'h_1
`define JCP_IR_SAMPLE 4'h_2
`define JCP_IR_CONFIG_IO 4'h_3
`define JCP_IR_PROGRAM 4'h_4
`define JCP_IR_PULSE_CONFIG 4'h_5
`define JCP_IR_CAPTURE 4'h_1
// Arbitrary identity value of our own making; it names no maker or part
`define JCP_IDCODE_VALUE 32'h_1234_5679
`define JCP_TMS_RESET_EDGES 5
`define JCP_FIFO_WIDTH 8
`define JCP_FIFO_DEPTH 16
`define JCP_FIFO_AW 4

`define JCP_ST_RESET 4'h_0
`define JCP_ST_IDLE 4'h_1
`define JCP_ST_SEL_DR 4'h_2
`define JCP_ST_CAP_DR 4'h_3
`define JCP_ST_SHIFT_DR 4'h_4
`define JCP_ST_EXIT1_DR 4'h_5
`define JCP_ST_PAUSE_DR 4'h_6
`define JCP_ST_EXIT2_DR 4'h_7
`define JCP_ST_UPD_DR 4'h_8
`define JCP_ST_SEL_IR 4'h_9
`define JCP_ST_CAP_IR 4'h_A
`define JCP_ST_SHIFT_IR 4'h_B
`define JCP_ST_EXIT1_IR 4'h_C
`define JCP_ST_PAUSE_IR 4'h_D
`define JCP_ST_EXIT2_IR 4'h_E
`define JCP_ST_UPD_IR 4'h_F

`endif

// ---- hw/jcp_fifo.v ----
// Purpose: Synchronous FIFO for configuration bytes
// Assumes: Single clock, synchronous active-high reset
// Notes: Depth is a power of two; full and empty are exact
module jcp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_clk, // System clock
    input wire i_reset, // Synchronous reset
    input wire [WIDTH-1:0] i_data, // Write data
    input wire i_valid, // Write request
    output wire o_ready, // Space available
    output wire [WIDTH-1:0] o_data, // Read data
    output wire o_valid, // Data available
    input wire i_ready // Reader takes data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire empty = (wr_ptr == rd_ptr);
    wire full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data = mem[rd_ptr[AW-1:0]];
    always @(posedge i_clk) begin
        if (i_valid && !full)
            mem[wr_ptr[AW-1:0]] <= i_data;
    end
    always @(posedge i_clk) begin
        if (i_reset) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (i_valid && !full)
                wr_ptr <= wr_ptr + 1'b1;
            if (i_ready && !empty)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// ---- hw/jcp_port.v ----
// Purpose: Test access port that also loads configuration data serially
// Assumes: Test clock far slower than i_clk; test clock, mode-select and data-in pins synchronised here
// Notes: Test-clock edges are found by sampling; a slow device stalls shifting
// What this block does
// - Test-port configuration overrides all other modes
// - Starting test-port load aborts passive serial
// - No serial clock out during test-port load
// - Test-port path takes uncompressed data only
// - User I/O tri-stated during test-port load
// - Data input sampled on test-clock rise
// - Data output changes on test-clock fall
// - Data output floats when not shifting
// - State advances on sampled mode-select at rise
// - Configuration data accepted through test port
// - Bypass is one-bit delay, in to out
// - Bypass, ID, sample run during other loads
// - Other instructions need I/O reconfiguration first
`include "jcp_map.vh"
module jcp_port (
    input wire i_clk, // System clock, 100 MHz
    input wire i_reset, // Synchronous reset, active high
    input wire i_tck, // Test clock pin
    input wire i_tms, // Test mode-select pin
    input wire i_tdi, // Test data input pin
    output reg o_tdo, // Test data output value
    output reg o_tdo_oe, // Test data output enable
    input wire [1:0] i_config_scheme_select_pins, // Scheme select straps
    input wire i_passive_serial_load, // Passive serial load in progress
    input wire i_config_serial_clock_req, // Active load wants serial clock
    output reg o_config_serial_clock_out, // Serial clock output value
    output reg o_config_serial_clock_oe, // Serial clock output enable
    output reg o_passive_serial_abort, // Abort the passive load
    output reg o_user_io_hiz, // Force user I/O high impedance
    output reg o_compressed_disable, // Decompressor off on this path
    output reg o_config_active, // Test-port load in progress
    output reg o_io_reconfig, // Other configuration interrupted
    output reg [`JCP_FIFO_WIDTH-1:0] o_cfg_data, // Configuration byte
    output reg o_cfg_valid, // Configuration byte valid
    input wire i_cfg_ready // Loader accepts byte
);
    reg [2:0] tck_s;
    reg [1:0] tms_s;
    reg [1:0] tdi_s;
    reg [3:0] state;
    reg [3:0] next_state;
    reg [`JCP_IR_WIDTH-1:0] ir_shift;
    reg [`JCP_IR_WIDTH-1:0] ir;
    reg [31:0] dr_shift;
    reg bypass_bit;
    reg [2:0] tms_high_cnt;
    reg [2:0] bit_cnt;
    reg [`JCP_FIFO_WIDTH-1:0] byte_acc;
    reg byte_push;
    wire fifo_ready;
    wire fifo_valid;
    wire [`JCP_FIFO_WIDTH-1:0] fifo_data;
    // Only tck_s[2:1] feed edge detection; tck_s[0] is the first stage
    wire tck_rise = tck_s[1] && !tck_s[2];
    wire tck_fall = !tck_s[1] && tck_s[2];
    wire tms = tms_s[1];
    wire tdi = tdi_s[1];
    wire programming = (ir == `JCP_IR_PROGRAM) && o_io_reconfig;
    wire shifting = (state == `JCP_ST_SHIFT_DR) || (state == `JCP_ST_SHIFT_IR);
    // Limitation: a test-clock rise that meets the stall is dropped, not deferred,
    // so the cable must leave the loader time to drain the FIFO
    // A full FIFO holds back the shift so the pending byte_acc is not overwritten
    wire dr_stall = programming && (state == `JCP_ST_SHIFT_DR) && !fifo_ready && byte_push;

    always @* begin
        next_state = state;
        case (state)
            `JCP_ST_RESET: next_state = tms ? `JCP_ST_RESET : `JCP_ST_IDLE;
            `JCP_ST_IDLE: next_state = tms ? `JCP_ST_SEL_DR : `JCP_ST_IDLE;
            `JCP_ST_SEL_DR: next_state = tms ? `JCP_ST_SEL_IR : `JCP_ST_CAP_DR;
            `JCP_ST_CAP_DR: next_state = tms ? `JCP_ST_EXIT1_DR : `JCP_ST_SHIFT_DR;
            `JCP_ST_SHIFT_DR: next_state = tms ? `JCP_ST_EXIT1_DR : `JCP_ST_SHIFT_DR;
            `JCP_ST_EXIT1_DR: next_state = tms ? `JCP_ST_UPD_DR : `JCP_ST_PAUSE_DR;
            `JCP_ST_PAUSE_DR: next_state = tms ? `JCP_ST_EXIT2_DR : `JCP_ST_PAUSE_DR;
            `JCP_ST_EXIT2_DR: next_state = tms ? `JCP_ST_UPD_DR : `JCP_ST_SHIFT_DR;
            `JCP_ST_UPD_DR: next_state = tms ? `JCP_ST_SEL_DR : `JCP_ST_IDLE;
            `JCP_ST_SEL_IR: next_state = tms ? `JCP_ST_RESET : `JCP_ST_CAP_IR;
            `JCP_ST_CAP_IR: next_state = tms ? `JCP_ST_EXIT1_IR : `JCP_ST_SHIFT_IR;
            `JCP_ST_SHIFT_IR: next_state = tms ? `JCP_ST_EXIT1_IR : `JCP_ST_SHIFT_IR;
            `JCP_ST_EXIT1_IR: next_state = tms ? `JCP_ST_UPD_IR : `JCP_ST_PAUSE_IR;
            `JCP_ST_PAUSE_IR: next_state = tms ? `JCP_ST_EXIT2_IR : `JCP_ST_PAUSE_IR;
            `JCP_ST_EXIT2_IR: next_state = tms ? `JCP_ST_UPD_IR : `JCP_ST_SHIFT_IR;
            `JCP_ST_UPD_IR: next_state = tms ? `JCP_ST_SEL_DR : `JCP_ST_IDLE;
            default: next_state = `JCP_ST_RESET;
        endcase
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            tck_s <= 3'h_0;
            tms_s <= 2'h_3;
            tdi_s <= 2'h_3;
        end else begin
            tck_s <= {tck_s[1:0], i_tck};
            tms_s <= {tms_s[0], i_tms};
            tdi_s <= {tdi_s[0], i_tdi};
        end
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            state <= `JCP_ST_RESET;
            ir <= `JCP_IR_IDCODE;
            ir_shift <= {`JCP_IR_WIDTH{1'b0}};
            dr_shift <= 32'h_0000_0000;
            bypass_bit <= 1'b0;
            tms_high_cnt <= 3'h_0;
            bit_cnt <= 3'h_0;
            byte_acc <= {`JCP_FIFO_WIDTH{1'b0}};
            byte_push <= 1'b0;
            o_io_reconfig <= 1'b0;
        end else begin
            if (byte_push && fifo_ready)
                byte_push <= 1'b0;
            if (tck_rise && !dr_stall) begin
                state <= next_state;
                if (tms && tms_high_cnt != `JCP_TMS_RESET_EDGES - 1)
                    tms_high_cnt <= tms_high_cnt + 3'h_1;
                else if (!tms)
                    tms_high_cnt <= 3'h_0;
                if (tms && tms_high_cnt == `JCP_TMS_RESET_EDGES - 1)
                    state <= `JCP_ST_RESET;
                case (state)
                    `JCP_ST_RESET: begin
                        ir <= `JCP_IR_IDCODE;
                        bit_cnt <= 3'h_0;
                    end
                    `JCP_ST_CAP_IR: ir_shift <= `JCP_IR_CAPTURE;
                    `JCP_ST_SHIFT_IR: ir_shift <= {tdi, ir_shift[`JCP_IR_WIDTH-1:1]};
                    `JCP_ST_UPD_IR: begin
                        // Non-passive instructions are refused until I/O is reconfigured
                        if (ir_shift == `JCP_IR_BYPASS || ir_shift == `JCP_IR_IDCODE ||
                            ir_shift == `JCP_IR_SAMPLE || ir_shift == `JCP_IR_CONFIG_IO ||
                            o_io_reconfig)
                            ir <= ir_shift;
                        else
                            ir <= `JCP_IR_BYPASS;
                        if (ir_shift == `JCP_IR_CONFIG_IO)
                            o_io_reconfig <= 1'b1;
                        if (ir_shift == `JCP_IR_PULSE_CONFIG && o_io_reconfig)
                            o_io_reconfig <= 1'b0;
                        bit_cnt <= 3'h_0;
                    end
                    `JCP_ST_CAP_DR: begin
                        bypass_bit <= 1'b0;
                        dr_shift <= (ir == `JCP_IR_IDCODE) ? `JCP_IDCODE_VALUE : 32'h_0000_0000;
                    end
                    `JCP_ST_SHIFT_DR: begin
                        bypass_bit <= tdi;
                        dr_shift <= {tdi, dr_shift[31:1]};
                        if (programming) begin
                            // Raw bits only; no decompression on this path
                            byte_acc <= {tdi, byte_acc[`JCP_FIFO_WIDTH-1:1]};
                            bit_cnt <= bit_cnt + 3'h_1;
                            if (bit_cnt == 3'h_7)
                                byte_push <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    jcp_fifo #(
        .WIDTH(`JCP_FIFO_WIDTH),
        .DEPTH(`JCP_FIFO_DEPTH),
        .AW(`JCP_FIFO_AW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_data(byte_acc),
        .i_valid(byte_push),
        .o_ready(fifo_ready),
        .o_data(fifo_data),
        .o_valid(fifo_valid),
        .i_ready(!o_cfg_valid || i_cfg_ready)
    );

    always @(posedge i_clk) begin
        if (i_reset) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
            o_config_serial_clock_out <= 1'b0;
            o_config_serial_clock_oe <= 1'b0;
            o_passive_serial_abort <= 1'b0;
            o_user_io_hiz <= 1'b0;
            o_compressed_disable <= 1'b0;
            o_config_active <= 1'b0;
            o_cfg_data <= {`JCP_FIFO_WIDTH{1'b0}};
            o_cfg_valid <= 1'b0;
        end else begin
            if (tck_fall) begin
                o_tdo_oe <= shifting;
                if (state == `JCP_ST_SHIFT_IR)
                    o_tdo <= ir_shift[0];
                else if (state == `JCP_ST_SHIFT_DR)
                    o_tdo <= (ir == `JCP_IR_BYPASS) ? bypass_bit : dr_shift[0];
            end
            // Status levels are registered so every pin comes straight from a flip-flop
            o_config_active <= programming;
            o_passive_serial_abort <= programming && i_passive_serial_load;
            o_user_io_hiz <= programming;
            o_compressed_disable <= programming;
            // Active schemes lose the serial clock while the test port loads
            o_config_serial_clock_oe <= !programming && i_config_scheme_select_pins[0];
            o_config_serial_clock_out <= !programming && i_config_serial_clock_req;
            if (!o_cfg_valid || i_cfg_ready) begin
                o_cfg_valid <= fifo_valid;
                o_cfg_data <= fifo_data;
            end
        end
    end
endmodule

// ---- dv/jcp_prog.sv ----
// Purpose: Programmer model driving the test port pins
// Assumes: Test clock rests low between frames, 125 ns period
// Notes: A floating data-out pin reads as the inverse of its value
module jcp_prog (
    output logic o_tck, // Test clock
    output logic o_tms, // Mode select
    output logic o_tdi, // Data in
    input wire logic i_tdo, // Data out value
    input wire logic i_tdo_oe // Data out enable
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_tck = 0;
        o_tms = 1;
        o_tdi = 1;
    end
    // Pins change only while the clock is low, well before the rise
    task step(input logic t, d, output logic q);
        o_tms = t;
        o_tdi = d;
        #62.5 q = i_tdo_oe ? i_tdo : ~i_tdo;
        o_tck = 1;
        #62.5 o_tck = 0;
    endtask
    task scan(input logic ir, input int n, input logic [31:0] d, output logic [31:0] q);
        logic b;
        q = 0;
        step(1, 1, b);
        if (ir)
            step(1, 1, b);
        step(0, 1, b);
        step(0, 1, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
        step(1, 1, b);
        step(0, 1, b);
    endtask
    task tap_reset;
        logic b;
        repeat (5) step(1, 1, b);
        step(0, 1, b);
    endtask
    task idle_clocks(input int n);
        logic b;
        repeat (n) step(0, 1, b);
    endtask
endmodule

// ---- dv/jcp_port_asserts.sv ----
// Purpose: Port-level checks for the test-port configuration block
// Assumes: Single clock domain, synchronous reset
// Notes: Pin timing is judged against the raw test clock input
module jcp_port_asserts (
    input wire i_clk, // Clock
    input wire i_reset, // Reset
    input wire i_tck, // Test clock
    input wire o_tdo, // Data out
    input wire o_tdo_oe, // Data out enable
    input wire i_passive_serial_load, // Passive load
    input wire o_config_serial_clock_out, // Serial clock
    input wire o_config_serial_clock_oe, // Serial clock enable
    input wire o_passive_serial_abort, // Abort
    input wire o_user_io_hiz, // User I/O float
    input wire o_compressed_disable, // No decompression
    input wire o_config_active, // Loading
    input wire o_io_reconfig, // Interrupted
    input wire [7:0] o_cfg_data, // Byte
    input wire o_cfg_valid, // Byte valid
    input wire i_cfg_ready // Byte taken
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    sequence s_loading;
        o_config_active && $past(o_config_active);
    endsequence
    sequence s_psl_load;
        (o_config_active && i_passive_serial_load) [*2];
    endsequence
    property p_hiz;
        s_loading |-> o_user_io_hiz;
    endproperty
    property p_nocmp;
        s_loading |-> o_compressed_disable;
    endproperty
    property p_sck;
        s_loading |-> !o_config_serial_clock_oe && !o_config_serial_clock_out;
    endproperty
    property p_abort;
        s_psl_load |-> o_passive_serial_abort;
    endproperty
    property p_no_abort;
        $rose(o_passive_serial_abort) |-> o_config_active && $past(i_passive_serial_load);
    endproperty
    property p_reconf;
        o_config_active |-> $past(o_io_reconfig);
    endproperty
    property p_tdo;
        $changed(o_tdo) |-> !i_tck && !$past(i_tck, 2);
    endproperty
    property p_oe;
        $changed(o_tdo_oe) |-> !i_tck && !$past(i_tck, 2);
    endproperty
    property p_hold;
        o_cfg_valid && !i_cfg_ready |=> o_cfg_valid && $stable(o_cfg_data);
    endproperty
    a_hiz: assert property (p_hiz) else $error("user io driven while loading");
    a_nocmp: assert property (p_nocmp) else $error("decompressor on");
    a_sck: assert property (p_sck) else $error("serial clock driven");
    a_abort: assert property (p_abort) else $error("passive load not aborted");
    a_no_abort: assert property (p_no_abort) else $error("stray abort");
    a_reconf: assert property (p_reconf) else $error("load without io reconfig");
    a_tdo: assert property (p_tdo) else $error("data out moved off a fall");
    a_oe: assert property (p_oe) else $error("data out enable moved off a fall");
    a_hold: assert property (p_hold) else $error("byte changed while stalled");
endmodule
bind jcp_port jcp_port_asserts u_asserts (
    .i_clk, .i_reset, .i_tck, .o_tdo, .o_tdo_oe, .i_passive_serial_load,
    .o_config_serial_clock_out, .o_config_serial_clock_oe, .o_passive_serial_abort,
    .o_user_io_hiz, .o_compressed_disable, .o_config_active, .o_io_reconfig,
    .o_cfg_data, .o_cfg_valid, .i_cfg_ready
);

// ---- dv/tb_jcp_port.sv ----
// Purpose: Self-checking bench for the test-port configuration block
// Assumes: Programmer model owns the test pins
// Notes: Flags pack the status outputs so one compare covers several
`include "jcp_map.vh"
module tb_jcp_port;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [3:0] ir; logic [31:0] din; logic [31:0] dout;} jcp_row_t;
    logic i_clk = 0;
    logic i_reset = 1;
    logic i_passive_serial_load = 0;
    logic i_cfg_ready = 0;
    logic [1:0] scheme = 2'h_1;
    logic sck_req = 1;
    wire i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe, o_config_serial_clock_out;
    wire o_config_serial_clock_oe, o_passive_serial_abort, o_user_io_hiz;
    wire o_compressed_disable, o_config_active, o_io_reconfig, o_cfg_valid;
    wire [7:0] o_cfg_data;
    wire [7:0] flags = {o_tdo_oe, o_config_serial_clock_oe, o_config_serial_clock_out,
        o_passive_serial_abort, o_user_io_hiz, o_compressed_disable, o_config_active, o_io_reconfig};
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [31:0] q;
    logic [7:0] got [$];
    // Codes 4 and 5 are refused before io reconfig and act as bypass
    jcp_row_t rows [4] = '{'{4'h_F, 32'h_A5C3_0F96, 32'h_4B86_1F2C},
        '{4'h_1, 32'h_A5C3_0F96, `JCP_IDCODE_VALUE},
        '{4'h_4, 32'h_A5C3_0F96, 32'h_4B86_1F2C}, '{4'h_5, 32'h_A5C3_0F96, 32'h_4B86_1F2C}};
    jcp_port u_dut (.i_clk, .i_reset, .i_tck, .i_tms, .i_tdi, .o_tdo, .o_tdo_oe,
        .i_config_scheme_select_pins(scheme), .i_passive_serial_load,
        .i_config_serial_clock_req(sck_req), .o_config_serial_clock_out,
        .o_config_serial_clock_oe, .o_passive_serial_abort, .o_user_io_hiz,
        .o_compressed_disable, .o_config_active, .o_io_reconfig, .o_cfg_data,
        .o_cfg_valid, .i_cfg_ready);
    jcp_prog u_prog (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo),
        .i_tdo_oe(o_tdo_oe));
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (o_cfg_valid && i_cfg_ready)
            got.push_back(o_cfg_data);
        if (cyc == 20000) begin
            miscompares++;
            wrap_up;
        end
    end
    task check(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task load_ir(input logic [3:0] c);
        u_prog.scan(1, 4, 32'(c), q);
        check("ir capture", q, 32'h_0000_0001);
    endtask
    task wrap_up;
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (11) @(posedge i_clk);
        check("reset flags", 32'(flags), 32'h_0000_0000);
        $display("Reset test done");
        @(posedge i_clk) #1 i_reset = 0;
        i_passive_serial_load = 1;
        u_prog.tap_reset;
        foreach (rows[i]) begin
            load_ir(rows[i].ir);
            u_prog.scan(0, 32, rows[i].din, q);
            check("dr out", q, rows[i].dout);
            check("flags", 32'(flags), 32'h_0000_0060);
            $display("Row %0d done", i);
        end
        load_ir(`JCP_IR_CONFIG_IO);
        check("flags", 32'(flags), 32'h_0000_0061);
        load_ir(`JCP_IR_PROGRAM);
        check("flags", 32'(flags), 32'h_0000_001F);
        // Four whole words leave 15 bytes in the FIFO and one in o_cfg_data; a fifth word would stall the shift
        for (int w = 0; w < 4; w++)
            u_prog.scan(0, 32, 32'h_0302_0100 + 32'(w) * 32'h_0404_0404, q);
        check("held", got.size(), 0);
        repeat (80) @(posedge i_clk) #1 i_cfg_ready = ~i_cfg_ready;
        check("bytes", got.size(), 16);
        foreach (got[k]) check("byte", 32'(got[k]), 32'(k));
        u_prog.idle_clocks(299);
        load_ir(`JCP_IR_PULSE_CONFIG);
        check("flags", 32'(flags), 32'h_0000_0060);
        $display("Configuration test done");
        load_ir(`JCP_IR_CONFIG_IO);
        load_ir(`JCP_IR_PROGRAM);
        u_prog.tap_reset;
        check("flags", 32'(flags), 32'h_0000_0061);
        u_prog.scan(0, 32, 32'h_0000_0000, q);
        check("idcode", q, `JCP_IDCODE_VALUE);
        $display("Controller reset test done");
        @(posedge i_clk) #1 scheme = 2'h_2;
        sck_req = 0;
        repeat (3) @(posedge i_clk);
        #1 check("passive scheme flags", 32'(flags), 32'h_0000_0001);
        $display("Scheme select test done");
        @(posedge i_clk) #1 i_reset = 1;
        repeat (2) @(posedge i_clk);
        #1 check("mid reset flags", 32'(flags), 32'h_0000_0000);
        @(posedge i_clk) #1 i_reset = 0;
        scheme = 2'h_1;
        sck_req = 1;
        u_prog.tap_reset;
        check("after reset flags", 32'(flags), 32'h_0000_0060);
        u_prog.scan(0, 32, 32'h_0000_0000, q);
        check("idcode after reset", q, `JCP_IDCODE_VALUE);
        load_ir(`JCP_IR_PROGRAM);
        check("refused flags", 32'(flags), 32'h_0000_0060);
        $display("Mid-run reset test done");
        wrap_up;
    end
endmodule
